// ==== nvc_defines.vh ====
// Constants for the host-side controller of a nonvolatile static memory.
// Assumes a 100 MHz mclk; times are kept in their own units.
`ifndef NVC_DEFINES_VH
`define NVC_DEFINES_VH
`define NVC_CLK_PS        10000
`define NVC_RC_NS         25
`define NVC_PWE_NS        20
`define NVC_RC_CYC        ((`NVC_RC_NS * 1000 + `NVC_CLK_PS - 1) / `NVC_CLK_PS)
`define NVC_PWE_CYC       ((`NVC_PWE_NS * 1000 + `NVC_CLK_PS - 1) / `NVC_CLK_PS)
`define NVC_SS_US         100
`define NVC_SS_CYC        (`NVC_SS_US * 100)
`define NVC_RECALL_US     200
`define NVC_RECALL_CYC    (`NVC_RECALL_US * 100)
`define NVC_PUR_MS        20
`define NVC_PUR_CYC       (`NVC_PUR_MS * 100000)
`define NVC_CNT_W         22
`define NVC_SEQ_LEN       6
`define NVC_OP_READ       2'h0
`define NVC_OP_WRITE      2'h1
`define NVC_OP_SEQ        2'h2
`endif

// ==== nvc_host.v ====
// Host controller that drives a nonvolatile static memory through its pins.
// Assumes the memory pins are wired through the testbench; data is split
// into input, output and output enable. One mclk domain, sync reset.
`timescale 1ns/1ns
`include "nvc_defines.vh"

// Behaviour
// - Write strobe high throughout read cycles
// - Store/busy pin held high during accesses
// - Address changes only while strobes inactive
// - Command sequence issued as read cycles
// - Six ordered reads, write strobe high
module nvc_host #(
  parameter AW       = 19,                 // Address width
  parameter DW       = 16,                 // Data width
  parameter WIDE     = 1,                  // 1 when organised 16-bit
  parameter PUR_CYC  = `NVC_PUR_CYC,       // Power-up restore wait
  parameter SS_CYC   = `NVC_SS_CYC,        // Command processing wait
  parameter REC_CYC  = `NVC_RECALL_CYC,    // Restore busy wait
  parameter [6*AW-1:0] SEQ_ADDR = {AW*6{1'b0}} // Command address table
) (
  // Clock and reset
  input  wire          mclk,
  input  wire          reset,
  // User request
  input  wire          req,                // Start pulse, taken when ready
  input  wire [1:0]    op,                 // Read, write or sequence
  input  wire [AW-1:0] addr,
  input  wire [DW-1:0] wdata,
  input  wire [1:0]    lanes,              // Bit1 upper, bit0 lower
  input  wire          hw_store,           // Request a pin-driven save
  output reg           ready,
  output reg           done,               // One-cycle answer pulse
  output reg  [DW-1:0] rdata,
  // Memory pins
  output reg  [AW-1:0] mem_addr,
  output reg           chip_sel_n,
  output reg           write_n,
  output reg           out_en_n,
  output reg           upper_lane_en_n,
  output reg           lower_lane_en_n,
  input  wire [DW-1:0] dq_in,
  output reg  [DW-1:0] dq_out,
  output reg           dq_oe,
  input  wire          store_busy_n_in,
  output reg           store_busy_n_out,
  output reg           store_busy_n_oe
);

  // One-hot states
  localparam [5:0] S_PWRUP = 6'h01;        // Restore after power-up
  localparam [5:0] S_IDLE  = 6'h02;
  localparam [5:0] S_SETUP = 6'h04;        // Address settles, strobes high
  localparam [5:0] S_PULSE = 6'h08;        // Strobes active
  localparam [5:0] S_GAP   = 6'h10;        // Strobes released
  localparam [5:0] S_WAIT  = 6'h20;        // Lockout wait

  reg [5:0]            state;              // Current state
  reg [`NVC_CNT_W-1:0] cnt;                // Cycle counter
  reg [2:0]            seq_idx;            // Command read index
  reg                  is_wr;              // Current cycle is a write
  reg                  is_seq;             // Current cycle is a command
  reg                  hw_pend;            // Pin save in progress
  reg                  sb_meta;            // Busy pin first stage
  reg                  sb_sync;            // Busy pin synchronised
  wire [AW-1:0]        seq_a;              // Next command address

  // Command table lookup, entry after the current index
  // table addresses
  assign seq_a = SEQ_ADDR[(seq_idx + 3'h1)*AW +: AW];

  // Busy pin synchroniser, device may hold it low while busy
  always @(posedge mclk) begin
    sb_meta <= store_busy_n_in;
    sb_sync <= sb_meta;
  end

  // Main sequencer
  always @(posedge mclk) begin
    if (reset) begin
      state            <= S_PWRUP;
      cnt              <= {`NVC_CNT_W{1'b0}};
      seq_idx          <= 3'h0;
      is_wr            <= 1'b0;
      is_seq           <= 1'b0;
      hw_pend          <= 1'b0;
      ready            <= 1'b0;
      done             <= 1'b0;
      rdata            <= {DW{1'b0}};
      mem_addr         <= {AW{1'b0}};
      chip_sel_n       <= 1'b1;
      write_n          <= 1'b1;
      out_en_n         <= 1'b1;
      upper_lane_en_n  <= 1'b1;
      lower_lane_en_n  <= 1'b1;
      dq_out           <= {DW{1'b0}};
      dq_oe            <= 1'b0;
      store_busy_n_out <= 1'b1;
      store_busy_n_oe  <= 1'b0;
    end else begin
      done <= 1'b0;
      case (state)
        S_PWRUP: begin
          // Device ignores accesses until its restore ends
          if (cnt == PUR_CYC[`NVC_CNT_W-1:0] - 1'b1) begin
            cnt   <= {`NVC_CNT_W{1'b0}};
            state <= S_IDLE;
            ready <= 1'b1;
          end else begin
            cnt <= cnt + 1'b1;
          end
        end
        S_IDLE: begin
          store_busy_n_out <= 1'b1;
          store_busy_n_oe  <= 1'b0;
          if (hw_store) begin
            store_busy_n_out <= 1'b0;
            store_busy_n_oe  <= 1'b1;
            hw_pend          <= 1'b1;
            ready            <= 1'b0;
            cnt              <= {`NVC_CNT_W{1'b0}};
            state            <= S_WAIT;
          end else if (req) begin
            ready  <= 1'b0;
            is_wr  <= (op == `NVC_OP_WRITE);
            is_seq <= (op == `NVC_OP_SEQ);
            seq_idx <= 3'h0;
            mem_addr <= (op == `NVC_OP_SEQ) ? SEQ_ADDR[AW-1:0] : addr;
            dq_out   <= wdata;
            cnt      <= {`NVC_CNT_W{1'b0}};
            state    <= S_SETUP;
          end
        end
        S_SETUP: begin
          // One cycle of setup, then assert strobes together
          chip_sel_n <= 1'b0;
          // write strobe stays high on reads
          write_n    <= ~is_wr;
          out_en_n   <= is_wr;
          dq_oe      <= is_wr;
          upper_lane_en_n <= (WIDE != 0) ? (is_seq ? 1'b0 : ~lanes[1]) : 1'b1;
          lower_lane_en_n <= (WIDE != 0) ? (is_seq ? 1'b0 : ~lanes[0]) : 1'b1;
          state      <= S_PULSE;
        end
        S_PULSE: begin
          if (cnt == `NVC_RC_CYC - 1) begin
            cnt   <= {`NVC_CNT_W{1'b0}};
            if (!is_wr)
              rdata <= dq_in;
            write_n    <= 1'b1;
            out_en_n   <= 1'b1;
            chip_sel_n <= 1'b1;
            upper_lane_en_n <= 1'b1;
            lower_lane_en_n <= 1'b1;
            state      <= S_GAP;
          end else begin
            cnt <= cnt + 1'b1;
          end
        end
        S_GAP: begin
          dq_oe <= 1'b0;
          if (is_seq && seq_idx != `NVC_SEQ_LEN - 1) begin
            seq_idx  <= seq_idx + 1'b1;
            mem_addr <= seq_a;
            state    <= S_SETUP;
          end else if (is_seq) begin
            cnt   <= {`NVC_CNT_W{1'b0}};
            state <= S_WAIT;
          end else begin
            done  <= 1'b1;
            ready <= 1'b1;
            state <= S_IDLE;
          end
        end
        S_WAIT: begin
          if (cnt >= SS_CYC[`NVC_CNT_W-1:0] + REC_CYC[`NVC_CNT_W-1:0]
              && (!hw_pend || sb_sync)) begin
            store_busy_n_out <= 1'b1;
            store_busy_n_oe  <= 1'b0;
            hw_pend <= 1'b0;
            done    <= 1'b1;
            ready   <= 1'b1;
            state   <= S_IDLE;
          end else begin
            if (hw_pend && cnt == `NVC_PWE_CYC)
              store_busy_n_oe <= 1'b0;   // Release pin, device drives busy
            cnt <= cnt + 1'b1;
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end

endmodule

// ==== nvc_mem_model.sv ====
// Behavioural memory device facing the host controller.
// Assumes one mclk; the bench resolves the shared busy pin.
`timescale 1ns/1ns
module nvc_mem_model #(parameter AW = 8) (
  // Clock
  input  wire          mclk,
  // Memory pins
  input  wire [AW-1:0] mem_addr,
  input  wire          chip_sel_n,
  input  wire          write_n,
  input  wire          out_en_n,
  input  wire          upper_lane_en_n,
  input  wire          lower_lane_en_n,
  input  wire [15:0]   dq_out,
  input  wire          store_pin,
  output logic [15:0]  dq_in,
  output logic         busy_drv,
  output int           n_store
);
  logic [15:0] mem [0:15];   // Low address bits only, enough here
  logic [15:0] last = 16'h0; // Floating bus shows inverse of this
  logic        dirty = 1'b0; // Written since last save
  int          busy = 0;     // Save cycles left
  wire [3:0]   a = mem_addr[3:0];
  wire rd = !chip_sel_n && write_n && !out_en_n && busy == 0;
  wire wr = !chip_sel_n && !write_n && busy == 0;
  initial n_store = 0;
  assign busy_drv = busy != 0;
  always_comb begin
    dq_in[7:0]  = (rd && !lower_lane_en_n) ? mem[a][7:0] : ~last[7:0];
    dq_in[15:8] = (rd && !upper_lane_en_n) ? mem[a][15:8] : ~last[15:8];
  end
  // timing covered by host waits only
  always @(posedge mclk) begin
    last <= dq_in;
    if (busy != 0) begin
      busy <= busy - 1;
    end else if (!store_pin && dirty) begin
      busy <= 5;
      dirty <= 1'b0;
      n_store <= n_store + 1;
    end else if (wr) begin
      if (!lower_lane_en_n) mem[a][7:0] <= dq_out[7:0];
      if (!upper_lane_en_n) mem[a][15:8] <= dq_out[15:8];
      dirty <= 1'b1;
    end
  end
endmodule

// ==== nvc_host_chk.sv ====
// Assertions on the host controller's ports.
// Assumes one mclk domain with synchronous active-high reset.
`timescale 1ns/1ns
module nvc_host_chk #(parameter AW = 19) (
  // Clock, reset and user side
  input wire          mclk,
  input wire          reset,
  input wire          req,
  input wire [1:0]    op,
  input wire          hw_store,
  input wire          ready,
  input wire          done,
  // Memory pins
  input wire [AW-1:0] mem_addr,
  input wire          chip_sel_n,
  input wire          write_n,
  input wire          out_en_n,
  input wire          dq_oe,
  input wire          store_busy_n_out,
  input wire          store_busy_n_oe
);
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  wire take = ready && req && !hw_store; // Request accepted
  a_rd_we_high: assert property (!chip_sel_n && !out_en_n |-> write_n)
    else $error("write strobe low in read");
  a_busy_free: assert property (!chip_sel_n |-> !(store_busy_n_oe && !store_busy_n_out))
    else $error("busy pin low in access");
  a_addr_move: assert property ($changed(mem_addr) |-> chip_sel_n || write_n)
    else $error("address moved in write");
  a_no_clash: assert property (!out_en_n |-> !dq_oe)
    else $error("host drives during read");
  a_wr_drive: assert property (!write_n |-> dq_oe && out_en_n)
    else $error("write without data drive");
  a_pulse_len: assert property ($fell(chip_sel_n) |-> !chip_sel_n [*3])
    else $error("select pulse too short");
  a_done_lat: assert property (take && op != 2'h2 |-> ##[6:7] done)
    else $error("access answer late");
  a_cmd_lock: assert property (take && op == 2'h2 |=> !ready [*8])
    else $error("ready during command");
  a_pur_wait: assert property ($fell(reset) |-> !ready [*8])
    else $error("ready before restore");
  c_write: cover property (take && op == 2'h1);
  c_cmd: cover property (take && op == 2'h2);
  c_store: cover property (ready && hw_store);
endmodule
bind nvc_host nvc_host_chk #(.AW(AW)) u_chk (.mclk(mclk), .reset(reset),
  .req(req), .op(op), .hw_store(hw_store), .ready(ready), .done(done),
  .mem_addr(mem_addr), .chip_sel_n(chip_sel_n), .write_n(write_n),
  .out_en_n(out_en_n), .dq_oe(dq_oe), .store_busy_n_out(store_busy_n_out),
  .store_busy_n_oe(store_busy_n_oe));

// ==== nvc_host_tb.sv ====
// Self-checking bench: host controller facing a memory model.
// Assumes the defines header is on the include path.
`timescale 1ns/1ns
module nvc_host_tb;
  logic        mclk = 0;
  logic        reset = 1;
  logic        req = 0;
  logic        hw_store = 0;
  logic        ok;
  logic [1:0]  op = 0;
  logic [1:0]  lanes = 0;
  logic [7:0]  addr = 0;
  logic [15:0] wdata = 0;
  wire         ready, done, cs_n, we_n, oe_n, dq_oe, up_n, lo_n;
  wire         busy_drv, sb_out, sb_oe;
  wire [15:0]  rdata, dq_in, dq_out;
  wire [7:0]   mem_addr;
  int          n_store, k;
  int          n_fail = 0;
  int          n_tests = 0;
  // Pulled-up busy pin, either side may pull it low
  wire store_pin = (sb_oe ? sb_out : 1'b1) && !busy_drv;
  always #5 mclk = ~mclk;
  nvc_host #(.AW(8), .PUR_CYC(20), .SS_CYC(10), .REC_CYC(10)) i_dut (
    .mclk(mclk), .reset(reset), .req(req), .op(op), .addr(addr),
    .wdata(wdata), .lanes(lanes), .hw_store(hw_store), .ready(ready),
    .done(done), .rdata(rdata), .mem_addr(mem_addr), .chip_sel_n(cs_n),
    .write_n(we_n), .out_en_n(oe_n), .upper_lane_en_n(up_n),
    .lower_lane_en_n(lo_n), .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe),
    .store_busy_n_in(store_pin), .store_busy_n_out(sb_out),
    .store_busy_n_oe(sb_oe));
  nvc_mem_model #(.AW(8)) i_mem (.mclk(mclk), .mem_addr(mem_addr),
    .chip_sel_n(cs_n), .write_n(we_n), .out_en_n(oe_n),
    .upper_lane_en_n(up_n), .lower_lane_en_n(lo_n), .dq_out(dq_out),
    .store_pin(store_pin), .dq_in(dq_in), .busy_drv(busy_drv),
    .n_store(n_store));
  task chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // One request, bounded waits for ready and done
  task run(input logic [1:0] o, input logic [7:0] a, input logic [15:0] d,
           input logic [1:0] l, input logic hs);
    for (k = 0; k < 300 && ready !== 1'b1; k++) @(negedge mclk);
    op = o;
    addr = a;
    wdata = d;
    lanes = l;
    req = !hs;
    hw_store = hs;
    @(negedge mclk);
    req = 0;
    hw_store = 0;
    for (k = 0; k < 300 && done !== 1'b1; k++) @(negedge mclk);
    ok = done;
    chk({15'h0, done}, 16'h0001);
  endtask
  task t_word;
    run(2'h1, 8'h03, 16'hA5C3, 2'h3, 0);
    run(2'h0, 8'h03, 16'h0000, 2'h3, 0);
    chk(rdata, 16'hA5C3);
  endtask
  task t_lane;
    run(2'h1, 8'h03, 16'h1234, 2'h2, 0);
    run(2'h0, 8'h03, 16'h0000, 2'h3, 0);
    chk(rdata, 16'h12C3);
    run(2'h1, 8'h03, 16'hAA55, 2'h1, 0);
    run(2'h0, 8'h03, 16'h0000, 2'h1, 0);
    chk({8'h00, rdata[7:0]}, 16'h0055);
  endtask
  task t_store;
    int s;
    s = n_store;
    run(2'h0, 8'h00, 16'h0000, 2'h0, 1);
    chk(16'(n_store - s), 16'h0001);
    run(2'h0, 8'h00, 16'h0000, 2'h0, 1);
    chk(16'(n_store - s), 16'h0001);
  endtask
  task t_seq;
    run(2'h2, 8'h00, 16'h0000, 2'h3, 0);
    chk({15'h0, ok}, 16'h0001);
    run(2'h0, 8'h03, 16'h0000, 2'h3, 0);
    chk(rdata, 16'h1255);
  endtask
  task conclude;
    if (n_fail == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Watchdog: runs take well under 20000 cycles
  initial begin
    #200000;
    n_fail++;
    conclude;
  end
  initial begin
    repeat (4) @(negedge mclk);
    reset = 0;
    t_word;
    t_lane;
    t_store;
    t_seq;
    conclude;
  end
endmodule
